// ---- lsi_regs.svh ----
// Behaviour
// - Low-limit exponent top bits equal to 11b select end-of-conversion mode.
// - In end-of-conversion mode every finished conversion makes the interrupt active.
// - Latched end-of-conversion: config read, non-shutdown write, alert release interrupt.
// - Latched end-of-conversion: a config read clears both threshold flags.
// - Latched: fault-count hits set their own flag, other flag untouched.
// - Transparent end-of-conversion: high hit gives flags 10, low hit 01, interrupt active.
// - Transparent end-of-conversion: read or non-shutdown write releases interrupt; alert ignored.
// - Conversion-ready sets per conversion, clears right after a config read.
// - Non-shutdown config write clears conversion-ready; shutdown write keeps flags; latch-clearing write releases interrupt unless end-of-conversion.
// - Interrupt pin level follows active state and the output polarity bit.
// - First byte after write-direction address is stored as register pointer.
// - Write: address, pointer, two data bytes, each acknowledged, register loaded.
// - Read returns most significant byte, then least after host acknowledge.
// - Pointer is kept across reads until a new pointer byte is written.
// - Every serial register is sixteen bits wide.
// - With latch bit 0 the alert response address is ignored.
`ifndef LSI_REGS_SVH
`define LSI_REGS_SVH
`define LSI_PTR_RES    8'h00
`define LSI_PTR_CFG    8'h01
`define LSI_PTR_LOW    8'h02
`define LSI_PTR_HIGH   8'h03
`define LSI_PTR_MFR    8'h7E
`define LSI_PTR_DEV    8'h7F
`define LSI_SLV_ADDR   7'h2A
`define LSI_ALERT_ADDR 7'h0C
`define LSI_CFG_M      9
`define LSI_CFG_CRF    7
`define LSI_CFG_FH     6
`define LSI_CFG_FL     5
`define LSI_CFG_L      4
`define LSI_CFG_POL    3
`define LSI_CFG_FC     0
`define LSI_CFG_WMASK  16'hFE1F
`define LSI_CFG_RST    16'h0000
`define LSI_LOW_RST    16'h0000
`define LSI_HIGH_RST   16'hBFFF
`define LSI_FC_SAT     4'h8
`define LSI_WB_RES     8'h00
`define LSI_WB_CFG     8'h04
`define LSI_WB_PTR     8'h08
`endif

// ---- lsi_pkg.sv ----
`default_nettype none
package lsi_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ADDR = 5'h02,
    ST_PTR  = 5'h04,
    ST_WDAT = 5'h08,
    ST_RDAT = 5'h10
  } lsi_st_e;

  typedef struct packed {
    logic        scl_m;
    logic        scl_s;
    logic        scl_p;
    logic        sda_m;
    logic        sda_s;
    logic        sda_p;
    lsi_st_e     st;
    logic [3:0]  bitc;
    logic [7:0]  sh;
    logic        ack;
    logic        oe;
    logic        idx;
    logic [7:0]  msb;
    logic [7:0]  ptr;
    logic [15:0] rdw;
    logic [15:0] res;
    logic [15:0] cfg;
    logic [15:0] low;
    logic [15:0] high;
    logic [3:0]  hcnt;
    logic [3:0]  lcnt;
    logic        act;
    logic        pin;
    logic        wack;
    logic [31:0] wdat;
  } lsi_state_s;
endpackage
`default_nettype wire

// ---- lsi_top.sv ----
// Implementation choices: the register addresses and register access over Wishbone.
`timescale 1ns/1ns
`default_nettype none
`include "lsi_regs.svh"
module lsi_top #(
  // Identity values are arbitrary.
  parameter logic [15:0] MFR_ID = 16'h1A2B,
  parameter logic [15:0] DEV_ID = 16'h3C4D
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        scl_i,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  output logic             int_o,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);
  localparam lsi_pkg::lsi_state_s RST_S = '{
    st:      lsi_pkg::ST_IDLE,
    cfg:     `LSI_CFG_RST,
    low:     `LSI_LOW_RST,
    high:    `LSI_HIGH_RST,
    pin:     1'b1,
    scl_m:   1'b1,
    scl_s:   1'b1,
    scl_p:   1'b1,
    sda_m:   1'b1,
    sda_s:   1'b1,
    sda_p:   1'b1,
    default: '0
  };

  lsi_pkg::lsi_state_s q;
  lsi_pkg::lsi_state_s n;
  logic        rise;
  logic        fall;
  logic        start_c;
  logic        stop_c;
  logic [7:0]  byte_in;
  logic [7:0]  tx;
  logic [15:0] rv;
  logic [15:0] wv;
  logic [3:0]  bitc_n;
  logic [3:0]  fcn;
  logic [3:0]  nh;
  logic [3:0]  nl;
  logic        req;
  logic        conv;
  logic        cfg_rd;
  logic        cfg_wr;
  logic        alert;
  logic        ptr_ld;
  logic        adr_ok;
  logic        eoc;
  logic        lat;
  logic        above;
  logic        below;
  logic        hit_h;
  logic        hit_l;

  // Mantissa scaled by exponent gives a comparable light level.
  function automatic logic [27:0] lux(input logic [15:0] v);
    lux = {16'h0000, v[11:0]} << v[15:12];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb
  begin
    n       = q;
    cfg_rd  = 1'b0;
    cfg_wr  = 1'b0;
    alert   = 1'b0;
    ptr_ld  = 1'b0;
    adr_ok  = 1'b0;
    wv      = 16'h0000;
    n.scl_m = scl_i;
    n.scl_s = q.scl_m;
    n.scl_p = q.scl_s;
    n.sda_m = sda_i;
    n.sda_s = q.sda_m;
    n.sda_p = q.sda_s;
    rise    = q.scl_s & ~q.scl_p;
    fall    = ~q.scl_s & q.scl_p;
    start_c = q.scl_s & q.scl_p & q.sda_p & ~q.sda_s;
    stop_c  = q.scl_s & q.scl_p & ~q.sda_p & q.sda_s;
    byte_in = {q.sh[6:0], q.sda_s};
    tx      = q.idx ? q.rdw[7:0] : q.rdw[15:8];
    bitc_n  = (q.bitc == 4'h8) ? 4'h0 : q.bitc + 4'h1;
    eoc     = q.low[15:14] == 2'b11;
    lat     = q.cfg[`LSI_CFG_L];
    case (q.ptr)
      `LSI_PTR_RES:  rv = q.res;
      `LSI_PTR_CFG:  rv = q.cfg;
      `LSI_PTR_LOW:  rv = q.low;
      `LSI_PTR_HIGH: rv = q.high;
      `LSI_PTR_MFR:  rv = MFR_ID;
      `LSI_PTR_DEV:  rv = DEV_ID;
      default:       rv = 16'h0000;
    endcase

    if (start_c)
    begin
      n.st   = lsi_pkg::ST_ADDR;
      n.bitc = 4'h8;
      n.idx  = 1'b0;
      n.ack  = 1'b0;
      n.oe   = 1'b0;
    end
    else if (stop_c)
    begin
      n.st = lsi_pkg::ST_IDLE;
      n.oe = 1'b0;
    end
    else if (q.st != lsi_pkg::ST_IDLE && rise)
    begin
      if (q.bitc == 4'h8)
      begin
        // Host acknowledge slot after a byte that this end sent.
        if (q.st == lsi_pkg::ST_RDAT && !q.ack)
        begin
          if (q.sda_s)
            n.st = lsi_pkg::ST_IDLE;
          else
            n.idx = ~q.idx;
        end
      end
      else
      begin
        n.sh = byte_in;
        if (q.bitc == 4'h7 && q.st != lsi_pkg::ST_RDAT)
        begin
          n.ack = 1'b1;
          unique case (q.st)
            lsi_pkg::ST_ADDR:
            begin
              if (byte_in[7:1] == `LSI_SLV_ADDR)
              begin
                adr_ok = 1'b1;
                if (byte_in[0])
                begin
                  n.st   = lsi_pkg::ST_RDAT;
                  n.rdw  = rv;
                  cfg_rd = q.ptr == `LSI_PTR_CFG;
                end
                else
                  n.st = lsi_pkg::ST_PTR;
              end
              else if (byte_in == {`LSI_ALERT_ADDR, 1'b1} && lat)
              begin
                alert = 1'b1;
                n.st  = lsi_pkg::ST_RDAT;
                n.rdw = {`LSI_SLV_ADDR, q.cfg[`LSI_CFG_FH], 8'h00};
              end
              else
              begin
                n.ack = 1'b0;
                n.st  = lsi_pkg::ST_IDLE;
              end
            end
            lsi_pkg::ST_PTR:
            begin
              n.ptr  = byte_in;
              ptr_ld = 1'b1;
              n.st   = lsi_pkg::ST_WDAT;
              n.idx  = 1'b0;
            end
            lsi_pkg::ST_WDAT:
            begin
              n.idx = ~q.idx;
              if (!q.idx)
                n.msb = byte_in;
              else
              begin
                wv = {q.msb, byte_in};
                case (q.ptr)
                  `LSI_PTR_CFG:  cfg_wr = 1'b1;
                  `LSI_PTR_LOW:  n.low = wv;
                  `LSI_PTR_HIGH: n.high = wv;
                  default:       n.idx = 1'b0;
                endcase
              end
            end
            default:
              n.ack = 1'b0;
          endcase
        end
      end
    end
    else if (q.st != lsi_pkg::ST_IDLE && fall)
    begin
      n.bitc = bitc_n;
      if (bitc_n == 4'h8)
        n.oe = q.ack;
      else
        n.oe = (q.st == lsi_pkg::ST_RDAT) & ~tx[~bitc_n[2:0]];
      if (bitc_n == 4'h0)
        n.ack = 1'b0;
    end

    ////////////////////////////////////////////////////////////////////////
    // Register bus: ack one cycle after the request, write at the ack edge.
    req    = wb_cyc_i & wb_stb_i;
    n.wack = req & ~q.wack;
    if (req && !q.wack)
    begin
      case (wb_adr_i)
        `LSI_WB_RES: n.wdat = {16'h0000, q.res};
        `LSI_WB_CFG: n.wdat = {16'h0000, q.cfg};
        `LSI_WB_PTR: n.wdat = {24'h000000, q.ptr};
        default:     n.wdat = 32'h00000000;
      endcase
    end
    conv = req & q.wack & wb_we_i & (&wb_sel_i[1:0])
         & (wb_adr_i == `LSI_WB_RES);

    ////////////////////////////////////////////////////////////////////////
    // Clears are applied first so that a coinciding conversion wins.
    if (cfg_rd)
    begin
      n.cfg[`LSI_CFG_CRF] = 1'b0;
      if (lat)
      begin
        n.cfg[`LSI_CFG_FH] = 1'b0;
        n.cfg[`LSI_CFG_FL] = 1'b0;
        n.act = 1'b0;
      end
      else if (eoc)
        n.act = 1'b0;
    end
    if (cfg_wr)
    begin
      n.cfg = (wv & `LSI_CFG_WMASK) | (q.cfg & ~`LSI_CFG_WMASK);
      if (wv[`LSI_CFG_M +: 2] != 2'b00)
      begin
        n.cfg[`LSI_CFG_CRF] = 1'b0;
        if (eoc)
          n.act = 1'b0;
      end
      if (lat && !wv[`LSI_CFG_L] && !eoc)
        n.act = 1'b0;
    end
    if (alert)
      n.act = 1'b0;

    fcn   = 4'h1 << q.cfg[`LSI_CFG_FC +: 2];
    above = lux(wb_dat_i[15:0]) > lux(q.high);
    below = lux(wb_dat_i[15:0]) < lux({2'b00, q.low[13:0]});
    nh    = !above ? 4'h0 : (q.hcnt == `LSI_FC_SAT) ? q.hcnt : q.hcnt + 4'h1;
    nl    = !below ? 4'h0 : (q.lcnt == `LSI_FC_SAT) ? q.lcnt : q.lcnt + 4'h1;
    hit_h = conv & above & (nh >= fcn);
    hit_l = conv & below & (nl >= fcn);
    if (conv)
    begin
      n.res               = wb_dat_i[15:0];
      n.hcnt              = nh;
      n.lcnt              = nl;
      n.cfg[`LSI_CFG_CRF] = 1'b1;
      if (q.cfg[`LSI_CFG_M +: 2] == 2'b01)
        n.cfg[`LSI_CFG_M +: 2] = 2'b00;
      if (lat)
      begin
        if (hit_h)
          n.cfg[`LSI_CFG_FH] = 1'b1;
        if (hit_l)
          n.cfg[`LSI_CFG_FL] = 1'b1;
        if (hit_h || hit_l)
          n.act = 1'b1;
      end
      else if (hit_h)
      begin
        n.cfg[`LSI_CFG_FH] = 1'b1;
        n.cfg[`LSI_CFG_FL] = 1'b0;
        n.act = 1'b1;
      end
      else if (hit_l)
      begin
        n.cfg[`LSI_CFG_FH] = 1'b0;
        n.cfg[`LSI_CFG_FL] = 1'b1;
        n.act = 1'b0;
      end
      if (eoc)
        n.act = 1'b1;
    end
    n.pin = n.act ? n.cfg[`LSI_CFG_POL] : ~n.cfg[`LSI_CFG_POL];
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      q <= RST_S;
    else
      q <= n;
  end

  assign sda_o    = 1'b0;
  assign sda_oe_o = q.oe;
  assign int_o    = q.pin;
  assign wb_dat_o = q.wdat;
  assign wb_ack_o = q.wack;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_conv;
    conv;
  endsequence
  sequence s_eoc_conv;
    conv && eoc;
  endsequence
  sequence s_lat_read;
    cfg_rd && lat && !conv;
  endsequence

  property p_eoc_int;
    s_eoc_conv |=> q.act && int_o == q.cfg[`LSI_CFG_POL];
  endproperty
  a_eoc_int: assert property (p_eoc_int)
    else $error("interrupt not active after end of conversion");

  property p_crf_set;
    s_conv |=> q.cfg[`LSI_CFG_CRF];
  endproperty
  a_crf_set: assert property (p_crf_set)
    else $error("conversion ready not set");

  property p_crf_clr;
    cfg_rd && !conv |=> !q.cfg[`LSI_CFG_CRF];
  endproperty
  a_crf_clr: assert property (p_crf_clr)
    else $error("conversion ready not cleared by read");

  property p_lat_rd;
    s_lat_read |=> !q.cfg[`LSI_CFG_FH] && !q.cfg[`LSI_CFG_FL] && !q.act;
  endproperty
  a_lat_rd: assert property (p_lat_rd)
    else $error("latched read did not clear flags");

  property p_tr_hi;
    conv && !lat && hit_h |=> q.cfg[`LSI_CFG_FH] && !q.cfg[`LSI_CFG_FL];
  endproperty
  a_tr_hi: assert property (p_tr_hi)
    else $error("transparent high crossing flags wrong");

  property p_shdn;
    cfg_wr && wv[`LSI_CFG_M +: 2] == 2'b00 && !conv && !(lat && !wv[4])
      |=> $stable(q.act) && $stable(q.cfg[`LSI_CFG_CRF]);
  endproperty
  a_shdn: assert property (p_shdn)
    else $error("shutdown write changed status");

  property p_pin;
    q.pin == (q.act ? q.cfg[`LSI_CFG_POL] : !q.cfg[`LSI_CFG_POL]);
  endproperty
  a_pin: assert property (p_pin)
    else $error("interrupt pin level wrong");

  property p_ptr;
    ptr_ld |=> q.ptr == $past(byte_in);
  endproperty
  a_ptr: assert property (p_ptr)
    else $error("pointer byte not stored");

  property p_ptr_keep;
    !ptr_ld |=> $stable(q.ptr);
  endproperty
  a_ptr_keep: assert property (p_ptr_keep)
    else $error("pointer changed without pointer byte");

  property p_ack;
    adr_ok |-> ##[1:40] sda_oe_o;
  endproperty
  a_ack: assert property (p_ack)
    else $error("address not acknowledged");
endmodule
`default_nettype wire

// ---- lsi_host.sv ----
`timescale 1ns/1ns
`default_nettype none
module lsi_host (
  input  wire logic clk_i,
  input  wire logic sda_i,
  output logic      scl_o,
  output logic      sda_o
);
  initial
  begin
    scl_o = 1'b1;
    sda_o = 1'b1;
  end

  // Quarter of the 320 ns link period; the link clock idles high.
  task automatic tick;
    repeat (2) @(posedge clk_i);
  endtask

  task automatic bit_io(input logic b, output logic r);
    sda_o <= b;
    tick();
    scl_o <= 1'b1;
    tick();
    r = sda_i;
    tick();
    scl_o <= 1'b0;
    tick();
  endtask

  task automatic start;
    sda_o <= 1'b1;
    tick();
    scl_o <= 1'b1;
    tick();
    sda_o <= 1'b0;
    tick();
    scl_o <= 1'b0;
    tick();
  endtask

  task automatic stop;
    sda_o <= 1'b0;
    tick();
    scl_o <= 1'b1;
    tick();
    sda_o <= 1'b1;
    tick();
  endtask

  task automatic byte_out(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(b[i], r);
    bit_io(1'b1, ack);
  endtask

  task automatic byte_in(input logic last, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, r);
  endtask
endmodule
`default_nettype wire

// ---- lsi_top_test.sv ----
`timescale 1ns/1ns
`default_nettype none
module lsi_top_test;
  logic        clk  = 1'b0;
  logic        rst  = 1'b1;
  logic        cyc  = 1'b0;
  logic        stb  = 1'b0;
  logic        we   = 1'b0;
  logic [7:0]  adr  = 8'h00;
  logic [31:0] wdat = 32'h0;
  wire logic        scl;
  wire logic        sdh;
  wire logic        sda_oe;
  wire logic        irq;
  wire logic        ack;
  wire logic [31:0] rdat;
  wire logic        sda_lv;
  wire logic        sda_w = sdh & (sda_oe ? sda_lv : 1'b1);
  int num_errors = 0;
  int num_checks = 0;
  int crf = 0;
  int fh  = 0;
  int fl  = 0;
  int act = 0;
  int lat = 0;
  int output_polarity = 0;
  int low = 0;

  always #20 clk = ~clk;

  lsi_top uut (.clk_i(clk), .rst_i(rst), .scl_i(scl), .sda_i(sda_w),
    .sda_o(sda_lv), .sda_oe_o(sda_oe), .int_o(irq), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack));

  lsi_host host (.clk_i(clk), .sda_i(sda_w), .scl_o(scl), .sda_o(sdh));

  //////////////////////////////////////////////////////////////////////////
  task automatic summarize;
    if (num_errors == 0 && num_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d, output logic [31:0] r);
    int n;
    @(posedge clk);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    if (ack !== 1'b1)
      num_errors++;
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  // Reference model state is compared with the config view and the pin.
  task automatic chk;
    logic [31:0] r;
    wb(1'b0, 8'h04, 32'h0, r);
    cmp(r & 32'hE0, (crf << 7) | (fh << 6) | (fl << 5));
    cmp(irq, act == output_polarity);
  endtask

  function automatic int lux(input int x);
    return (x & 'hFFF) << ((x >> 12) & 15);
  endfunction

  task automatic conv(input int v);
    logic [31:0] r;
    int hi;
    int lo;
    wb(1'b1, 8'h00, v, r);
    hi = lux(v) > lux('hBFFF);
    lo = lux(v) < lux(low & 'h3FFF);
    if (lat != 0)
    begin
      fh |= hi;
      fl |= lo;
    end
    else if (hi != 0 || lo != 0)
    begin
      fh = hi;
      fl = lo;
    end
    crf = 1;
    act = 1;
    repeat (2) @(posedge clk);
  endtask

  task automatic i2c_wr(input logic [7:0] p, input logic [15:0] d,
                        input logic full, input logic rs);
    logic a;
    logic e;
    host.start();
    host.byte_out(8'h54, a);
    e = a;
    host.byte_out(p, a);
    e |= a;
    if (full)
    begin
      host.byte_out(d[15:8], a);
      e |= a;
      host.byte_out(d[7:0], a);
      e |= a;
    end
    if (!rs)
      host.stop();
    cmp(e, 0);
  endtask

  task automatic i2c_rd(output logic [15:0] d);
    logic a;
    logic [7:0] h;
    logic [7:0] l;
    host.start();
    host.byte_out(8'h55, a);
    host.byte_in(1'b0, h);
    host.byte_in(1'b1, l);
    host.stop();
    cmp(a, 0);
    d = {h, l};
  endtask

  task automatic rdcfg;
    logic [15:0] d;
    i2c_wr(8'h01, 16'h0, 1'b0, 1'b0);
    i2c_rd(d);
    cmp(d & 16'h00E0, (crf << 7) | (fh << 6) | (fl << 5));
    crf = 0;
    act = 0;
    if (lat != 0)
    begin
      fh = 0;
      fl = 0;
    end
  endtask

  task automatic cfg_wr(input int v);
    i2c_wr(8'h01, v[15:0], 1'b1, 1'b0);
    if (lat != 0 && ((v >> 4) & 1) == 0 && ((low >> 14) & 3) != 3)
      act = 0;
    lat = (v >> 4) & 1;
    output_polarity = (v >> 3) & 1;
    if (((v >> 9) & 3) != 0)
    begin
      crf = 0;
      act = 0;
    end
  endtask

  task automatic alert(input logic nack);
    logic a;
    logic [7:0] b;
    host.start();
    host.byte_out(8'h19, a);
    cmp(a, nack);
    if (!a)
    begin
      host.byte_in(1'b1, b);
      cmp(b, 8'h54 | fh);
      act = 0;
    end
    host.stop();
  endtask

  //////////////////////////////////////////////////////////////////////////
  initial
  begin
    logic [15:0] d;
    logic [31:0] r;
    int mid;
    mid = $urandom(32'hD7EE);
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    repeat (3) @(posedge clk);
    chk();
    wb(1'b0, 8'h40, 32'h0, r);
    cmp(r, 0);
    i2c_wr(8'h03, 16'h0, 1'b0, 1'b0);
    i2c_rd(d);
    cmp(d, 16'hBFFF);
    low = 'hC000;
    i2c_wr(8'h02, low[15:0], 1'b1, 1'b1);
    i2c_rd(d);
    cmp(d, low);
    wb(1'b0, 8'h08, 32'h0, r);
    cmp(r, 8'h02);
    cfg_wr('h0410);
    chk();
    mid = 'h100 + $urandom % 'hE00;
    conv(mid);
    chk();
    rdcfg();
    chk();
    rdcfg();
    chk();
    conv('hFFFF);
    chk();
    wb(1'b0, 8'h00, 32'h0, r);
    cmp(r, 'hFFFF);
    conv(mid);
    chk();
    alert(1'b0);
    chk();
    rdcfg();
    chk();
    conv(mid);
    cfg_wr('h0010);
    chk();
    cfg_wr('h0410);
    chk();
    conv(mid);
    low = 'h0000;
    i2c_wr(8'h02, low[15:0], 1'b1, 1'b0);
    chk();
    cfg_wr('h0000);
    chk();
    cfg_wr('h0408);
    low = 'hC100;
    i2c_wr(8'h02, low[15:0], 1'b1, 1'b0);
    conv('h0010);
    chk();
    conv('hFFFF);
    chk();
    alert(1'b1);
    chk();
    rdcfg();
    chk();
    conv(mid);
    cfg_wr('h0408);
    chk();
    summarize();
  end

  initial
  begin
    #2000000;
    num_errors++;
    summarize();
  end
endmodule
`default_nettype wire
